// ==== inc/port_pin_map.vh ====
/*
  Constants for the eight-pin port: register offsets on the
  Avalon-MM slave, field positions and reset values.
  Assumes inclusion by bare name from the design files.
*/
`ifndef PORT_PIN_MAP_VH
`define PORT_PIN_MAP_VH

`define PORT_WIDTH        8
`define ADDR_WIDTH        4
`define REG_OUT_VALUE     4'h0
`define REG_DIR           4'h1
`define REG_PIN_INPUT     4'h2
`define REG_CONTROL       4'h3
`define REG_IRQ_FLAGS     4'h4
`define CTRL_PULLUP_OFF   0
`define CTRL_SLEEP        1
`define RST_BYTE          8'h00
`define UNMAPPED_DATA     32'h00000000

`endif

// ==== hw/pin_sync_stage.v ====
/*
  Holds the per-port input synchroniser: a falling-edge stage that keeps
  what a latch open while the clock is high would hold, followed by a
  flop on the next rising edge.
  Assumes the pad levels arrive asynchronously to core_clk.
*/
`timescale 1ns/10ps
`include "port_pin_map.vh"

module pin_sync_stage (
  input  wire       core_clk,    // io clock
  input  wire       sys_rst,     // async reset, active high
  input  wire [7:0] padIn,       // gated pad levels
  output reg  [7:0] syncOut_r    // synchronised pin input bits
);

  reg [7:0] latchQ;

  // closes on the falling edge like the latch; a real latch would race
  // the rising-edge flop below
  always @(negedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      latchQ <= `RST_BYTE;
    end else begin
      latchQ <= padIn;
    end
  end

  // flop loads on the following rising edge; total delay half to 1.5 cycles
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      syncOut_r <= `RST_BYTE;
    end else begin
      syncOut_r <= latchQ;
    end
  end

endmodule // pin_sync_stage

// ==== hw/pin_drive_slice.v ====
/*
  Holds the combinational override logic of one pin: pull-up, driver
  enable, driven value and digital input gating.
  Assumes override signals come from on-chip logic on the same clock.
*/
`timescale 1ns/10ps

module pin_drive_slice (
  input  wire dirBit,          // direction bit
  input  wire outValueBit,     // output value bit
  input  wire globalPullupOff, // shared pull-up disable
  input  wire sleepClamp,      // shared sleep clamp
  input  wire extIrqEn,        // external interrupt enabled
  input  wire pullOvrEn,       // pull-up override enable
  input  wire pullOvrVal,      // pull-up override value
  input  wire driveOvrEn,      // direction override enable
  input  wire driveOvrVal,     // direction override value
  input  wire valueOvrEn,      // value override enable
  input  wire valueOvrVal,     // value override value
  input  wire inputGateOvrEn,  // input enable override enable
  input  wire inputGateOvrVal, // input enable override value
  input  wire padRaw,          // pad level after input buffer
  output wire pullupEn,        // pull-up on
  output wire driveEn,         // output driver on
  output wire driveVal,        // value driven
  output wire gatedIn          // clamped level before schmitt
);

  wire inputEn;

  // pull-up: override value or {dir,out,off}=010
  assign pullupEn = pullOvrEn ? pullOvrVal
                  : ({dirBit, outValueBit, globalPullupOff} == 3'h2);

  // direction: 1 output, 0 input
  assign driveEn  = driveOvrEn ? driveOvrVal : dirBit;
  assign driveVal = valueOvrEn ? valueOvrVal : outValueBit;

  // irq pins escape the clamp so the pin input bits still see them in sleep
  assign inputEn = inputGateOvrEn ? inputGateOvrVal
                 : (~sleepClamp | extIrqEn);
  assign gatedIn = padRaw & inputEn;

endmodule // pin_drive_slice

// ==== hw/port_pin_sync_override.v ====
/*
  Eight-pin general purpose port with synchroniser, sleep clamp and
  alternate-function overrides, reached over Avalon-MM.
  Assumes pads are resolved outside from enable, value and pull-up.
*/
// The register addresses and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
`include "port_pin_map.vh"

module port_pin_sync_override (
  input  wire        core_clk,          // io clock, 250 MHz
  input  wire        sys_rst,           // async reset, active high
  input  wire [3:0]  address,           // avalon word address
  input  wire        read,              // avalon read
  input  wire        write,             // avalon write
  input  wire [31:0] writedata,         // avalon write data
  input  wire [3:0]  byteenable,        // avalon byte enables
  output reg  [31:0] readdata,          // avalon read data
  output reg         waitrequest,       // avalon wait
  input  wire [7:0]  padIn,             // pad levels, asynchronous
  output reg  [7:0]  padOe,             // pad output enables
  output reg  [7:0]  padOut,            // pad output values
  output reg  [7:0]  padPullupEn,       // pad pull-up enables
  output reg  [7:0]  altFuncInput,      // schmitt level to peripherals
  input  wire [7:0]  extIrqEn,          // ext interrupt enable per pin
  input  wire [7:0]  extIrqAsync,       // pin set to edge/change sense
  input  wire [7:0]  pullOvrEn,         // pull-up override enable
  input  wire [7:0]  pullOvrVal,        // pull-up override value
  input  wire [7:0]  driveOvrEn,        // direction override enable
  input  wire [7:0]  driveOvrVal,       // direction override value
  input  wire [7:0]  valueOvrEn,        // value override enable
  input  wire [7:0]  valueOvrVal,       // value override value
  input  wire [7:0]  toggleOvrEn,       // toggle override pulse
  input  wire [7:0]  inputGateOvrEn,    // input enable override enable
  input  wire [7:0]  inputGateOvrVal,   // input enable override value
  output reg  [7:0]  wakeIrqFlag        // flags set on wake from clamp
);

  reg  [7:0]  outValue_r;
  reg  [7:0]  outValue_nxt;
  reg  [7:0]  dir_r;
  reg  [1:0]  ctrl_r;
  reg  [7:0]  padSync1_r;
  reg  [7:0]  clampHigh_r;
  reg         sleepPrev_r;
  reg  [7:0]  irqFlag_nxt;
  wire [7:0]  pinInput;
  wire [7:0]  gatedIn;
  wire [7:0]  pullupEn;
  wire [7:0]  driveEn;
  wire [7:0]  driveVal;
  wire        pullupOff;
  wire        sleepClamp;
  wire        doWrite;
  wire        lane0;

  // strobes shared by the whole port
  assign doWrite    = write & ~waitrequest;
  assign lane0      = byteenable[0];
  assign pullupOff  = ctrl_r[`CTRL_PULLUP_OFF];
  assign sleepClamp = ctrl_r[`CTRL_SLEEP];

  // register read mux, zero above the byte and for holes
  function [31:0] readMux;
    input [3:0] addr;
    input [7:0] outV;
    input [7:0] dirV;
    input [7:0] pinV;
    input [1:0] ctrlV;
    input [7:0] flagV;
    begin
      case (addr)
        `REG_OUT_VALUE: readMux = {24'h000000, outV};
        `REG_DIR:       readMux = {24'h000000, dirV};
        `REG_PIN_INPUT: readMux = {24'h000000, pinV};
        `REG_CONTROL:   readMux = {30'h00000000, ctrlV};
        `REG_IRQ_FLAGS: readMux = {24'h000000, flagV};
        default:        readMux = `UNMAPPED_DATA;
      endcase
    end
  endfunction

  // eight identical slices
  genvar gi;
  generate
    for (gi = 0; gi < `PORT_WIDTH; gi = gi + 1) begin : gSlice
      pin_drive_slice uSlice (
        .dirBit          (dir_r[gi]),
        .outValueBit     (outValue_r[gi]),
        .globalPullupOff (pullupOff),
        .sleepClamp      (sleepClamp),
        .extIrqEn        (extIrqEn[gi]),
        .pullOvrEn       (pullOvrEn[gi]),
        .pullOvrVal      (pullOvrVal[gi]),
        .driveOvrEn      (driveOvrEn[gi]),
        .driveOvrVal     (driveOvrVal[gi]),
        .valueOvrEn      (valueOvrEn[gi]),
        .valueOvrVal     (valueOvrVal[gi]),
        .inputGateOvrEn  (inputGateOvrEn[gi]),
        .inputGateOvrVal (inputGateOvrVal[gi]),
        .padRaw          (padIn[gi]),
        .pullupEn        (pullupEn[gi]),
        .driveEn         (driveEn[gi]),
        .driveVal        (driveVal[gi]),
        .gatedIn         (gatedIn[gi])
      );
    end
  endgenerate

  // latch plus flop synchroniser feeding the pin input bits
  pin_sync_stage uSync (
    .core_clk  (core_clk),
    .sys_rst   (sys_rst),
    .padIn     (gatedIn),
    .syncOut_r (pinInput)
  );

  // next output value: write, pin-input toggle, override toggle
  always @* begin
    outValue_nxt = outValue_r;
    if (doWrite && lane0 && address == `REG_OUT_VALUE) begin
      outValue_nxt = writedata[7:0];
    end
    if (doWrite && lane0 && address == `REG_PIN_INPUT) begin
      outValue_nxt = outValue_nxt ^ writedata[7:0];
    end
    outValue_nxt = outValue_nxt ^ toggleOvrEn;
  end

  // control registers
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      outValue_r <= `RST_BYTE;
      dir_r      <= `RST_BYTE;
      ctrl_r     <= 2'h0;
    end else begin
      outValue_r <= outValue_nxt;
      if (doWrite && lane0 && address == `REG_DIR) begin
        dir_r <= writedata[7:0];
      end
      if (doWrite && lane0 && address == `REG_CONTROL) begin
        ctrl_r <= writedata[1:0];
      end
    end
  end

  // wake flag: clamp forced a high pin low; leaving sleep is the edge
  always @* begin
    irqFlag_nxt = wakeIrqFlag;
    if (doWrite && lane0 && address == `REG_IRQ_FLAGS) begin
      irqFlag_nxt = irqFlag_nxt & ~writedata[7:0];
    end
    if (sleepPrev_r && !sleepClamp) begin
      irqFlag_nxt = irqFlag_nxt | clampHigh_r;
    end
  end

  // pad level for wake detection, two flops before any logic
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      padSync1_r   <= `RST_BYTE;
      clampHigh_r  <= `RST_BYTE;
      sleepPrev_r  <= 1'b0;
      wakeIrqFlag  <= `RST_BYTE;
      altFuncInput <= `RST_BYTE;
    end else begin
      padSync1_r   <= padIn;
      clampHigh_r  <= altFuncInput & extIrqAsync & ~extIrqEn;
      sleepPrev_r  <= sleepClamp;
      wakeIrqFlag  <= irqFlag_nxt;
      altFuncInput <= padSync1_r;
    end
  end

  // pad controls registered; reset tri-states and drops pull-ups
  // analog link needs no logic: it joins the pad outside this block
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      padOe       <= `RST_BYTE;
      padOut      <= `RST_BYTE;
      padPullupEn <= `RST_BYTE;
    end else begin
      padOe       <= driveEn;
      padOut      <= driveVal;
      padPullupEn <= pullupEn;
    end
  end

  // single-cycle bus answer: one wait cycle, then accept
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      waitrequest <= 1'b1;
      readdata    <= `UNMAPPED_DATA;
    end else begin
      waitrequest <= ~((read | write) & waitrequest);
      if ((read | write) && waitrequest) begin
        readdata <= readMux(address, outValue_r, dir_r, pinInput,
                            ctrl_r, wakeIrqFlag);
      end
    end
  end

endmodule // port_pin_sync_override

// ==== testbench/port_pin_sync_override_asserts.sv ====
/* checker for the port: bus handshake and pad control relations.
   assumes it is bound to the top module ports. */
`timescale 1ns/10ps
module port_pin_sync_override_asserts (
  input wire logic        core_clk,        // io clock
  input wire logic        sys_rst,         // async reset
  input wire logic        read,            // bus read
  input wire logic        write,           // bus write
  input wire logic [31:0] readdata,        // bus read data
  input wire logic        waitrequest,     // bus wait
  input wire logic [7:0]  padIn,           // pad levels
  input wire logic [7:0]  padOe,           // driver enables
  input wire logic [7:0]  padOut,          // driven values
  input wire logic [7:0]  padPullupEn,     // pull-ups
  input wire logic [7:0]  altFuncInput,    // level to peripherals
  input wire logic [7:0]  pullOvrEn,       // pull override enable
  input wire logic [7:0]  pullOvrVal,      // pull override value
  input wire logic [7:0]  driveOvrEn,      // direction override
  input wire logic [7:0]  driveOvrVal,     // direction value
  input wire logic [7:0]  valueOvrEn,      // value override
  input wire logic [7:0]  valueOvrVal,     // value override value
  input wire logic [7:0]  inputGateOvrEn,  // input gate override
  input wire logic [7:0]  inputGateOvrVal  // input gate value
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // one wait cycle, then a single accept cycle
  AST_WAIT_ONE: assert property (
    (read || write) && waitrequest |=> !waitrequest)
    else $error("no accept after request");
  AST_WAIT_PULSE: assert property (!waitrequest |=> waitrequest)
    else $error("accept longer than one cycle");
  AST_READ_HIGH: assert property (
    read && !waitrequest |-> readdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  // reset must not be masked here: it is the cause; the first edge
  // only starts the async clear, so look one edge later
  AST_RESET_PULL: assert property (disable iff (1'b0)
    sys_rst |=> padPullupEn == 8'h00 && padOe == 8'h00)
    else $error("pull-up or driver on in reset");
  AST_PULL_OVR: assert property (
    (pullOvrEn == 8'hFF && $stable(pullOvrVal)) [*3]
    |-> padPullupEn == pullOvrVal)
    else $error("pull override ignored");
  AST_DRIVE_OVR: assert property (
    (driveOvrEn == 8'hFF && $stable(driveOvrVal)) [*3]
    |-> padOe == driveOvrVal)
    else $error("direction override ignored");
  AST_VALUE_OVR: assert property (
    (valueOvrEn == 8'hFF && $stable(valueOvrVal)) [*3]
    |-> (padOut & padOe) == (valueOvrVal & padOe))
    else $error("value override ignored");
  // a forced driver may legally meet a pull-up, so plain pins only
  AST_PULL_EXCL: assert property (
    pullOvrEn == 8'h00 && driveOvrEn == 8'h00
    && $stable(pullOvrEn) && $stable(driveOvrEn)
    |-> (padOe & padPullupEn) == 8'h00)
    else $error("pull-up on a driven pin");
  // two flops behind the pad, so two quiet edges suffice; four are checked
  AST_ALT_IN: assert property ($stable(padIn) [*4]
    |-> altFuncInput == padIn)
    else $error("peripheral input lags pad");
  CVR_WRITE: cover property (write && !waitrequest);
  CVR_READ: cover property (read && !waitrequest);
  CVR_DRIVE: cover property ((driveOvrEn == 8'hFF) [*3]);
endmodule // port_pin_sync_override_asserts

bind port_pin_sync_override port_pin_sync_override_asserts chk_u (
  .core_clk(core_clk), .sys_rst(sys_rst), .read(read), .write(write),
  .readdata(readdata), .waitrequest(waitrequest), .padIn(padIn),
  .padOe(padOe), .padOut(padOut), .padPullupEn(padPullupEn),
  .altFuncInput(altFuncInput), .pullOvrEn(pullOvrEn),
  .pullOvrVal(pullOvrVal), .driveOvrEn(driveOvrEn),
  .driveOvrVal(driveOvrVal), .valueOvrEn(valueOvrEn),
  .valueOvrVal(valueOvrVal), .inputGateOvrEn(inputGateOvrEn),
  .inputGateOvrVal(inputGateOvrVal));

// ==== testbench/pad_model.sv ====
/* pad and external world model: resolves each pad level.
   assumes the bench sets external drive per pin. */
`timescale 1ns/10ps
module pad_model (
  input  wire logic       core_clk,    // io clock
  input  wire logic [7:0] padOe,       // device drives
  input  wire logic [7:0] padOut,      // device value
  input  wire logic [7:0] padPullupEn, // device pull-ups
  input  wire logic [7:0] extEn,       // outside drives
  input  wire logic [7:0] extVal,      // outside value
  output wire logic [7:0] padIn        // resolved level
);
  logic [7:0] floatPat_r = 8'h55;
  // floating pads wander so a stale level never looks valid
  always @(posedge core_clk) floatPat_r <= ~floatPat_r;
  // device driver wins, then outside drive, then pull-up
  assign padIn = (padOe & padOut) | (~padOe & extEn & extVal)
    | (~padOe & ~extEn & (padPullupEn | floatPat_r & ~padPullupEn));
endmodule // pad_model

// ==== testbench/port_pin_sync_override_test.sv ====
/* self-checking bench for the port over Avalon-MM.
   assumes pad_model and the bound checker are compiled. */
`timescale 1ns/10ps
module port_pin_sync_override_test;
  logic core_clk = 0, sys_rst = 1, read = 0, write = 0, waitrequest;
  logic [3:0] address = 4'h0, byteenable = 4'hF;
  logic [31:0] writedata = 32'h0, readdata, rdVal;
  logic [7:0] padIn, padOe, padOut, padPullupEn, altFuncInput, wakeIrqFlag;
  logic [7:0] extEn = 8'h00, extVal = 8'h00, extIrqEn = 8'h00;
  logic [7:0] extIrqAsync = 8'h00, toggleOvrEn = 8'h00;
  logic [7:0] pullOvrEn = 8'h00, pullOvrVal = 8'h00, driveOvrEn = 8'h00;
  logic [7:0] driveOvrVal = 8'h00, valueOvrEn = 8'h00, valueOvrVal = 8'h00;
  logic [7:0] inputGateOvrEn = 8'h00, inputGateOvrVal = 8'h00;
  int errors = 0, tests_run = 0, cycles = 0;

  port_pin_sync_override dut_u (.core_clk(core_clk), .sys_rst(sys_rst),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .padIn(padIn), .padOe(padOe),
    .padOut(padOut), .padPullupEn(padPullupEn),
    .altFuncInput(altFuncInput), .extIrqEn(extIrqEn),
    .extIrqAsync(extIrqAsync), .pullOvrEn(pullOvrEn),
    .pullOvrVal(pullOvrVal), .driveOvrEn(driveOvrEn),
    .driveOvrVal(driveOvrVal), .valueOvrEn(valueOvrEn),
    .valueOvrVal(valueOvrVal), .toggleOvrEn(toggleOvrEn),
    .inputGateOvrEn(inputGateOvrEn), .inputGateOvrVal(inputGateOvrVal),
    .wakeIrqFlag(wakeIrqFlag));
  pad_model pads_u (.core_clk(core_clk), .padOe(padOe), .padOut(padOut),
    .padPullupEn(padPullupEn), .extEn(extEn), .extVal(extVal),
    .padIn(padIn));

  initial forever #2 core_clk = ~core_clk;
  // hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // request held until waitrequest is sampled low at an edge
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [7:0] d);
    @(posedge core_clk);
    address <= a;
    writedata <= {24'h000000, d};
    write <= wr;
    read <= ~wr;
    do @(posedge core_clk); while (waitrequest !== 1'b0);
    rdVal = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask
  task automatic settle();
    repeat (4) @(posedge core_clk);
  endtask

  task automatic test_basic();
    extEn <= 8'h30;
    extVal <= 8'h10;
    bus(1, 4'h1, 8'h0F);
    bus(1, 4'h0, 8'hC3);
    settle();
    chk(padOe, 8'h0F);
    chk(padOut & 8'h0F, 8'h03);
    chk(padPullupEn, 8'hC0);
    bus(0, 4'h2, 8'h00);
    chk(rdVal, 32'hD3);
    bus(1, 4'h3, 8'h01);
    settle();
    chk(padPullupEn, 8'h00);
    bus(1, 4'h3, 8'h00);
    bus(0, 4'hF, 8'h00);
    chk(rdVal, 32'h0);
  endtask
  task automatic test_toggle();
    bus(1, 4'h2, 8'h01);
    @(posedge core_clk);
    bus(0, 4'h2, 8'h00);
    chk(rdVal, 32'hD2);
    bus(0, 4'h0, 8'h00);
    chk(rdVal, 32'hC2);
    @(posedge core_clk) toggleOvrEn <= 8'h02;
    @(posedge core_clk) toggleOvrEn <= 8'h00;
    bus(0, 4'h0, 8'h00);
    chk(rdVal, 32'hC0);
  endtask
  task automatic test_override();
    @(posedge core_clk);
    {driveOvrEn, driveOvrVal} <= 16'hFFAA;
    {valueOvrEn, valueOvrVal} <= 16'hFF55;
    {pullOvrEn, pullOvrVal} <= 16'hFF0F;
    settle();
    chk(padOe, 8'hAA);
    chk(padOut & 8'hAA, 8'h00);
    chk(padPullupEn, 8'h0F);
    driveOvrEn <= 8'h00;
    valueOvrEn <= 8'h00;
    pullOvrEn <= 8'h00;
  endtask
  // pin0 interrupt on, pin2 gate override, pin1 clamped and async
  task automatic test_sleep();
    extEn <= 8'hFF;
    extVal <= 8'h07;
    @(posedge core_clk);
    extIrqEn <= 8'h01;
    extIrqAsync <= 8'h02;
    {inputGateOvrEn, inputGateOvrVal} <= 16'h0404;
    bus(1, 4'h1, 8'h00);
    bus(1, 4'h3, 8'h02);
    settle();
    bus(0, 4'h2, 8'h00);
    chk(rdVal, 32'h05);
    chk(altFuncInput, 8'h07);
    bus(1, 4'h3, 8'h00);
    settle();
    chk(wakeIrqFlag, 8'h02);
    bus(1, 4'h4, 8'hFF);
    settle();
    chk(wakeIrqFlag, 8'h00);
  endtask
  // pins 6 and 7 still ask for pull-ups when reset strikes mid-run
  task automatic test_reset();
    @(posedge core_clk) sys_rst <= 1'b1;
    @(posedge core_clk);
    chk(padPullupEn, 8'h00);
    chk(padOe, 8'h00);
    sys_rst <= 1'b0;
    bus(0, 4'h0, 8'h00);
    chk(rdVal, 32'h0);
  endtask

  task automatic report_and_stop();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge core_clk);
    chk(padPullupEn, 8'h00);
    chk(waitrequest, 1'b1);
    sys_rst <= 1'b0;
    test_basic();
    test_toggle();
    test_override();
    test_sleep();
    test_reset();
    report_and_stop();
  end
endmodule // port_pin_sync_override_test
